// File: reset_source_defines.svh
`ifndef RESET_SOURCE_DEFINES_SVH
`define RESET_SOURCE_DEFINES_SVH
// Byte offsets of the register words.
`define OFS_FLAGS       4'h0
`define OFS_CTRL        4'h4
`define OFS_IRQ_STAT    4'h8
`define OFS_IRQ_MASK    4'hc
// Reset cause flag positions.
`define FLG_POWER_ON    7
`define FLG_PIN         6
`define FLG_WDOG        5
`define FLG_OPCODE      4
`define FLG_ADDRESS     3
`define FLG_LOW_V       1
`define FLAGS_POR_VAL   8'h82
`define FLAGS_LOWV_VAL  8'h02
// Control bit positions and values.
`define CTL_WDOG_EN     0
`define CTL_STOP_EN     1
`define CTL_BDM_EN      2
`define CTL_FORCE       7
`define CTL_RESET_VAL   8'h01
`define CTL_READ_MASK   8'h07
// Watchdog service values.
`define SVC_ARM         8'h55
`define SVC_FIRE        8'haa
// Interrupt status positions.
`define IRQ_RESET       0
`define IRQ_REFRESH     1
`define IRQ_BITS        8'h03
// Default counts.
`define HOLD_DEFAULT    16
`define WDOG_DEFAULT    262144
`endif

// File: reset_source_pkg.sv
`default_nettype none
package reset_source_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [31:0] word_t;
	// Watchdog service sequence tracker.
	typedef enum logic [1:0] {
		SVC_IDLE  = 2'b01,
		SVC_ARMED = 2'b10
	} svc_state_e;
	// System reset sequencer.
	typedef enum logic [1:0] {
		SEQ_RUN  = 2'b01,
		SEQ_HOLD = 2'b10
	} seq_state_e;
endpackage : reset_source_pkg
`default_nettype wire

// File: reset_source_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_defines.svh"

module reset_source_status #(
	parameter int HOLD_CYCLES  = `HOLD_DEFAULT,
	parameter int WDOG_TIMEOUT = `WDOG_DEFAULT
) (
	input  wire logic                  clk_in,
	input  wire logic                  arst_n_in,
	input  wire logic                  wb_cyc_in,
	input  wire logic                  wb_stb_in,
	input  wire logic                  wb_we_in,
	input  wire logic [3:0]            wb_adr_in,
	input  wire logic [3:0]            wb_sel_in,
	input  wire reset_source_pkg::word_t wb_dat_in,
	output var  reset_source_pkg::word_t wb_dat_out,
	output logic                       wb_ack_out,
	input  wire logic                  ext_reset_n_in,
	input  wire logic                  low_voltage_in,
	input  wire logic                  illegal_opcode_in,
	input  wire logic                  stop_exec_in,
	input  wire logic                  background_exec_in,
	input  wire logic                  illegal_address_in,
	output logic                       system_reset_out,
	output logic                       irq_out
);
	import reset_source_pkg::*;

	localparam int WDOG_W = $clog2(WDOG_TIMEOUT + 1);
	localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);

	byte_t              flags_reg;
	byte_t              ctrl_reg;
	byte_t              stat_reg;
	byte_t              mask_reg;
	byte_t              rd_next;
	logic               ack_reg;
	word_t              dat_reg;
	logic               irq_reg;
	logic               sys_reset_reg;
	logic               pin_meta_reg;
	logic               pin_sync_reg;
	logic               lv_meta_reg;
	logic               lv_sync_reg;
	logic [WDOG_W-1:0]  wdog_cnt_reg;
	logic [HOLD_W-1:0]  hold_cnt_reg;
	svc_state_e         svc_reg;
	seq_state_e         seq_reg;
	logic               after_por_reg;
	logic               wb_req;
	logic               wr_flags;
	logic               wr_ctrl;
	logic               wr_stat;
	logic               wr_mask;
	logic               adr_miss;
	logic               run;
	logic               pin_low;
	logic               low_v;
	logic               opc_bad;
	logic               adr_bad;
	logic               force_rst;
	logic               bad_svc;
	logic               timeout;
	logic               wdog_trip;
	logic               refresh;
	logic               entry;
	byte_t              wr_byte;

	// Decodes whether a byte offset names a register.
	function automatic logic addr_mapped(input logic [3:0] adr);
		addr_mapped = (adr == `OFS_FLAGS) || (adr == `OFS_CTRL) ||
			(adr == `OFS_IRQ_STAT) || (adr == `OFS_IRQ_MASK);
	endfunction : addr_mapped

	// Bus decode; one access per request, answered one cycle later.
	assign wb_req   = wb_cyc_in & wb_stb_in & ~ack_reg;
	assign wr_byte  = wb_dat_in[7:0];
	assign wr_flags = wb_req & wb_we_in & wb_sel_in[0] & (wb_adr_in == `OFS_FLAGS);
	assign wr_ctrl  = wb_req & wb_we_in & wb_sel_in[0] & (wb_adr_in == `OFS_CTRL);
	assign wr_stat  = wb_req & wb_we_in & wb_sel_in[0] & (wb_adr_in == `OFS_IRQ_STAT);
	assign wr_mask  = wb_req & wb_we_in & wb_sel_in[0] & (wb_adr_in == `OFS_IRQ_MASK);
	assign adr_miss = wb_req & ~addr_mapped(wb_adr_in);

	// Reset sources seen while the system runs.
	assign run       = (seq_reg == SEQ_RUN);
	assign pin_low   = ~pin_sync_reg;
	assign low_v     = lv_sync_reg;
	assign opc_bad   = illegal_opcode_in |
		(stop_exec_in & ~ctrl_reg[`CTL_STOP_EN]) |
		(background_exec_in & ~ctrl_reg[`CTL_BDM_EN]);
	assign adr_bad   = illegal_address_in | adr_miss;
	assign force_rst = wr_ctrl & wr_byte[`CTL_FORCE];
	assign bad_svc   = wr_flags & (wr_byte != `SVC_ARM) & (wr_byte != `SVC_FIRE);
	assign timeout   = (wdog_cnt_reg == WDOG_W'(WDOG_TIMEOUT - 1));
	assign wdog_trip = run & ctrl_reg[`CTL_WDOG_EN] & (timeout | bad_svc);
	assign refresh   = (svc_reg == SVC_ARMED) & wr_flags & (wr_byte == `SVC_FIRE);
	assign entry     = run & (pin_low | low_v | opc_bad | adr_bad | force_rst | wdog_trip);

	// Two-flop synchronisers for the asynchronous pins.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_meta_reg <= 1'b1;
			pin_sync_reg <= 1'b1;
			lv_meta_reg  <= 1'b0;
			lv_sync_reg  <= 1'b0;
		end else begin
			pin_meta_reg <= ext_reset_n_in;
			pin_sync_reg <= pin_meta_reg;
			lv_meta_reg  <= low_voltage_in;
			lv_sync_reg  <= lv_meta_reg;
		end
	end

	// Cause capture; power-on is the asynchronous reset itself.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flags_reg <= `FLAGS_POR_VAL;
		end else if (entry) begin
			if (low_v) begin
				flags_reg <= `FLAGS_LOWV_VAL;
				flags_reg[`FLG_POWER_ON] <= flags_reg[`FLG_POWER_ON];
			end else begin
				flags_reg <= 8'h00;
				flags_reg[`FLG_PIN]  <= pin_low;
				flags_reg[`FLG_WDOG] <= wdog_trip;
				flags_reg[`FLG_OPCODE]  <= opc_bad;
				flags_reg[`FLG_ADDRESS] <= adr_bad;
			end
		end
	end

	// Reset sequencer; held while pin or low voltage stay active.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			seq_reg       <= SEQ_RUN;
			hold_cnt_reg  <= '0;
			sys_reset_reg <= 1'b0;
		end else begin
			unique case (seq_reg)
				SEQ_RUN: begin
					if (entry) begin
						seq_reg       <= SEQ_HOLD;
						hold_cnt_reg  <= HOLD_W'(HOLD_CYCLES);
						sys_reset_reg <= 1'b1;
					end
				end
				SEQ_HOLD: begin
					if (pin_low | low_v) begin
						hold_cnt_reg <= HOLD_W'(HOLD_CYCLES);
					end else if (hold_cnt_reg != '0) begin
						hold_cnt_reg <= hold_cnt_reg - 1'b1;
					end else begin
						seq_reg       <= SEQ_RUN;
						sys_reset_reg <= 1'b0;
					end
				end
			endcase
		end
	end

	// Control word; the force bit is a pulse and is not stored.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_reg <= `CTL_RESET_VAL;
		end else if (!run) begin
			ctrl_reg <= `CTL_RESET_VAL;
		end else if (wr_ctrl) begin
			ctrl_reg <= wr_byte & `CTL_READ_MASK;
		end
	end

	// Service tracker: 0x55 arms, only a following 0xAA refreshes.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			svc_reg <= SVC_IDLE;
		end else if (!run) begin
			svc_reg <= SVC_IDLE;
		end else if (wr_flags) begin
			unique case (svc_reg)
				SVC_IDLE:  svc_reg <= (wr_byte == `SVC_ARM) ? SVC_ARMED : SVC_IDLE;
				SVC_ARMED: svc_reg <= (wr_byte == `SVC_ARM) ? SVC_ARMED : SVC_IDLE;
			endcase
		end
	end

	// Watchdog counter; runs only while enabled and the system runs.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wdog_cnt_reg <= '0;
		end else if (!run || !ctrl_reg[`CTL_WDOG_EN] || refresh) begin
			wdog_cnt_reg <= '0;
		end else if (!timeout) begin
			wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
		end
	end

	// Sticky events; a new event wins over a clearing write.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stat_reg <= 8'h00;
			mask_reg <= 8'h00;
		end else begin
			stat_reg <= (stat_reg & ~(wr_stat ? wr_byte : 8'h00)) |
				{6'h00, refresh, entry};
			if (wr_mask) begin
				mask_reg <= wr_byte & `IRQ_BITS;
			end
		end
	end

	// Interrupt level follows the masked status one cycle later.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(stat_reg & mask_reg);
		end
	end

	// Read multiplexer; unmapped offsets read zero.
	always_comb begin
		rd_next = 8'h00;
		unique case (wb_adr_in)
			`OFS_FLAGS:    rd_next = flags_reg;
			`OFS_CTRL:     rd_next = ctrl_reg & `CTL_READ_MASK;
			`OFS_IRQ_STAT: rd_next = stat_reg;
			`OFS_IRQ_MASK: rd_next = mask_reg;
			default:       rd_next = 8'h00;
		endcase
	end

	// Bus answer: acknowledge one cycle after the request.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ack_reg <= 1'b0;
			dat_reg <= '0;
		end else begin
			ack_reg <= wb_req;
			if (wb_req && !wb_we_in) begin
				dat_reg <= {24'h000000, rd_next};
			end
		end
	end

	// Marks the first cycle after power-on release.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			after_por_reg <= 1'b0;
		end else begin
			after_por_reg <= 1'b1;
		end
	end

	assign wb_ack_out       = ack_reg;
	assign wb_dat_out       = dat_reg;
	assign irq_out          = irq_reg;
	assign system_reset_out = sys_reset_reg;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	// Valid service writes never alter the flags.
	a_flags_read_only: assert property (
		wr_flags && !bad_svc && !entry |=> $stable(flags_reg))
		else $error("flags changed on a service write");

	// A lone forced reset records no cause.
	a_force_no_cause: assert property (
		entry && force_rst && !pin_low && !low_v && !opc_bad && !adr_bad && !wdog_trip
		|=> flags_reg == 8'h00 && system_reset_out)
		else $error("forced reset left a flag set");

	// A bad service value resets with the watchdog flag.
	a_bad_service: assert property (
		run && ctrl_reg[`CTL_WDOG_EN] && bad_svc && !low_v
		|=> system_reset_out && flags_reg[`FLG_WDOG])
		else $error("bad service value did not reset");

	// A full service sequence clears the counter, flags kept.
	a_refresh_clears: assert property (
		run && svc_reg == SVC_ARMED && wr_flags && wr_byte == `SVC_FIRE && !entry
		|=> wdog_cnt_reg == '0 && $stable(flags_reg))
		else $error("service sequence did not refresh");

	// Power-on leaves exactly bits 7 and 1 set.
	a_por_value: assert property (
		!after_por_reg |-> flags_reg == `FLAGS_POR_VAL)
		else $error("power-on flags wrong");

	// Low voltage keeps bit 7 and sets bit 1 only.
	a_lowv_value: assert property (
		entry && low_v |=> flags_reg[6:0] == 7'h02 &&
		flags_reg[`FLG_POWER_ON] == $past(flags_reg[`FLG_POWER_ON]))
		else $error("low-voltage flags wrong");

	// Other resets clear bits 7 and 1 and take the sources.
	a_other_value: assert property (
		entry && !low_v |=> !flags_reg[`FLG_POWER_ON] && !flags_reg[`FLG_LOW_V]
		&& flags_reg[`FLG_OPCODE] == $past(opc_bad) && flags_reg[`FLG_ADDRESS] == $past(adr_bad))
		else $error("other-reset flags wrong");

	// A synchronised low pin is seen one edge later as a reset.
	a_pin_flag: assert property (
		run && !low_v && pin_low |=> system_reset_out && flags_reg[`FLG_PIN])
		else $error("pin reset not flagged");

	// A disabled watchdog never resets.
	a_wdog_blocked: assert property (
		run && !ctrl_reg[`CTL_WDOG_EN] && !(pin_low | low_v | opc_bad | adr_bad | force_rst)
		|=> !system_reset_out && wdog_cnt_reg == '0)
		else $error("disabled watchdog tripped");

	// An illegal opcode reports through bit 4.
	a_opcode_flag: assert property (
		run && !low_v && illegal_opcode_in |=> flags_reg[`FLG_OPCODE] && system_reset_out)
		else $error("illegal opcode not flagged");

	// Stop with stop disabled is an illegal opcode.
	a_stop_illegal: assert property (
		run && !low_v && stop_exec_in && !ctrl_reg[`CTL_STOP_EN] |=> flags_reg[`FLG_OPCODE])
		else $error("disabled stop not flagged");

	// Background entry with the mode off is illegal.
	a_background_illegal: assert property (
		run && !low_v && background_exec_in && !ctrl_reg[`CTL_BDM_EN] |=> flags_reg[`FLG_OPCODE])
		else $error("disabled background entry not flagged");

	// Reserved bits read zero on the bus.
	a_zero_bits: assert property (
		wb_req && !wb_we_in && wb_adr_in == `OFS_FLAGS |=> wb_ack_out
		&& wb_dat_out[2] == 1'b0 && wb_dat_out[0] == 1'b0)
		else $error("reserved flag bit set");

	// An unmapped access raises the address reset.
	a_address_flag: assert property (
		run && !low_v && adr_miss |=> flags_reg[`FLG_ADDRESS] && system_reset_out)
		else $error("unmapped access not flagged");

	// 0xAA without a preceding 0x55 does not refresh.
	a_lone_fire: assert property (
		run && ctrl_reg[`CTL_WDOG_EN] && !entry && svc_reg == SVC_IDLE && wr_flags
		&& wr_byte == `SVC_FIRE && !timeout |=> wdog_cnt_reg != '0)
		else $error("lone 0xAA refreshed the watchdog");

endmodule : reset_source_status
`default_nettype wire

// File: reset_sources_model.sv
`timescale 1ns/1ps
`default_nettype none
// Reset sources beside the block: CPU and decoder events pulse once, pin and supply faults stand four cycles.
module reset_sources_model (
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	input  wire logic       fire_in,
	input  wire logic [2:0] kind_in,
	output logic            ext_reset_n_out,
	output logic            low_voltage_out,
	output logic            illegal_opcode_out,
	output logic            stop_exec_out,
	output logic            background_exec_out,
	output logic            illegal_address_out
);
	logic [2:0] hold_reg;
	logic       lv_reg;
	// One event per fire request, of the kind given with it.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			{illegal_opcode_out, stop_exec_out, background_exec_out, illegal_address_out} <= 4'h0;
			hold_reg <= 3'h0;
			lv_reg   <= 1'b0;
		end else begin
			illegal_opcode_out  <= fire_in && kind_in == 3'h0;
			stop_exec_out       <= fire_in && kind_in == 3'h1;
			background_exec_out <= fire_in && kind_in == 3'h2;
			illegal_address_out <= fire_in && kind_in == 3'h3;
			if (fire_in && kind_in[2]) begin
				hold_reg <= 3'h4;
				lv_reg   <= kind_in[0];
			end else if (hold_reg != 3'h0) begin
				hold_reg <= hold_reg - 3'h1;
			end
		end
	end
	// The pin is pulled low, or the supply reported low, only while a fault stands.
	assign ext_reset_n_out = !(hold_reg != 3'h0 && !lv_reg);
	assign low_voltage_out = hold_reg != 3'h0 && lv_reg;
endmodule : reset_sources_model
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import reset_source_pkg::*;
	logic       clk_in = 1'b0;
	logic       arst_n_in = 1'b0;
	logic       cyc = 1'b0;
	logic       we = 1'b0;
	logic [3:0] adr = 4'h0;
	word_t      wdat = 32'h0;
	word_t      wb_dat_out;
	logic       wb_ack_out;
	logic       fire = 1'b0;
	logic [2:0] kind = 3'h0;
	logic       pin_n, lv, opc, stp, bgd, adr_bad, system_reset_out, irq_out;
	word_t      exp_q[$];
	int         fail_count = 0;
	int         total_checks = 0;
	int         cycles = 0;
	int         seed = 30;
	byte_t      bad;
	// Clock at 10 MHz.
	initial begin
		forever #50 clk_in = ~clk_in;
	end
	reset_source_status #(.HOLD_CYCLES(2), .WDOG_TIMEOUT(128)) i_dut (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_dat_out(wb_dat_out),
		.wb_ack_out(wb_ack_out), .ext_reset_n_in(pin_n), .low_voltage_in(lv), .illegal_opcode_in(opc),
		.stop_exec_in(stp), .background_exec_in(bgd), .illegal_address_in(adr_bad),
		.system_reset_out(system_reset_out), .irq_out(irq_out));
	reset_sources_model i_src (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .fire_in(fire), .kind_in(kind), .ext_reset_n_out(pin_n),
		.low_voltage_out(lv), .illegal_opcode_out(opc), .stop_exec_out(stp), .background_exec_out(bgd),
		.illegal_address_out(adr_bad));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic check_word(input word_t got, input word_t exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check_word
	task automatic check1(input logic got, input logic exp);
		check_word({31'h0, got}, {31'h0, exp});
	endtask : check1
	// One classic cycle: hold the request until ack is sampled high, then release.
	task automatic wb_xfer(input logic [3:0] a, input logic w, input byte_t d);
		int n;
		@(posedge clk_in);
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		cyc <= 1'b0;
	endtask : wb_xfer
	task automatic wb_read(input logic [3:0] a, input byte_t e);
		exp_q.push_back({24'h0, e});
		wb_xfer(a, 1'b0, 8'h0);
	endtask : wb_read
	task automatic fire_src(input logic [2:0] k);
		@(posedge clk_in);
		fire <= 1'b1;
		kind <= k;
		@(posedge clk_in);
		fire <= 1'b0;
	endtask : fire_src
	// A system reset must start within lim cycles and end within 50.
	task automatic wait_rst(input int lim);
		int n;
		n = 0;
		while (system_reset_out !== 1'b1 && n < lim) begin
			@(posedge clk_in);
			n++;
		end
		check1(system_reset_out, 1'b1);
		n = 0;
		while (system_reset_out !== 1'b0 && n < 50) begin
			@(posedge clk_in);
			n++;
		end
		check1(system_reset_out, 1'b0);
	endtask : wait_rst
	task automatic cause(input logic [2:0] k, input byte_t e);
		fire_src(k);
		wait_rst(20);
		wb_read(4'h0, e);
	endtask : cause
	// Every read answer is matched against the oldest expectation.
	always @(posedge clk_in) begin
		if (wb_ack_out === 1'b1 && we === 1'b0) begin
			if (exp_q.size() == 0) fail_count++;
			else check_word(wb_dat_out, exp_q.pop_front());
		end
	end
	// A hang ends the run as a failure.
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		repeat (5) @(posedge clk_in);
		arst_n_in <= 1'b1;
		wb_read(4'h0, 8'h82);
		wb_read(4'h4, 8'h01);
		wb_xfer(4'h0, 1'b1, 8'h55);
		wb_xfer(4'h0, 1'b1, 8'haa);
		check1(system_reset_out, 1'b0);
		wb_read(4'h0, 8'h82);
		wb_read(4'h8, 8'h02);
		check1(irq_out, 1'b0);
		wb_xfer(4'h8, 1'b1, 8'h03);
		wb_read(4'h8, 8'h00);
		wb_xfer(4'hc, 1'b1, 8'h01);
		wb_xfer(4'h0, 1'b1, 8'haa);
		wb_read(4'h8, 8'h00);
		cause(3'h0, 8'h10);
		check1(irq_out, 1'b1);
		wb_xfer(4'h8, 1'b1, 8'h01);
		repeat (2) @(posedge clk_in);
		check1(irq_out, 1'b0);
		cause(3'h1, 8'h10);
		cause(3'h2, 8'h10);
		cause(3'h3, 8'h08);
		cause(3'h4, 8'h40);
		cause(3'h5, 8'h02);
		wb_read(4'h2, 8'h00);
		wait_rst(20);
		wb_read(4'h0, 8'h08);
		bad = byte_t'($random(seed));
		if (bad == 8'h55 || bad == 8'haa) bad = 8'h12;
		wb_xfer(4'h0, 1'b1, bad);
		wait_rst(20);
		wb_read(4'h0, 8'h20);
		wb_xfer(4'h4, 1'b1, 8'h80);
		wait_rst(20);
		wb_read(4'h0, 8'h00);
		wb_xfer(4'h4, 1'b1, 8'h06);
		wb_xfer(4'h0, 1'b1, bad);
		fire_src(3'h1);
		fire_src(3'h2);
		repeat (4) @(posedge clk_in);
		check1(system_reset_out, 1'b0);
		wb_read(4'h4, 8'h06);
		wb_read(4'h0, 8'h00);
		wb_xfer(4'h4, 1'b1, 8'h01);
		wait_rst(300);
		wb_read(4'h0, 8'h20);
		repeat (3) @(posedge clk_in);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
